// *** logic/led_drv_pkg.sv ***
// Constants shared by the serial LED sink driver logic
package led_drv_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int CHANNELS        = 16;
  localparam int PIN_COUNT       = 4;
  // Bit positions of the pin inputs inside the synchroniser vector
  localparam int PIN_ENABLE_N    = 0;
  localparam int PIN_STROBE      = 1;
  localparam int PIN_SHIFT_CLK   = 2;
  localparam int PIN_SER_DATA    = 3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  // Enable idles high (pull-up), strobe idles low (pull-down)
  localparam logic [3:0]  PIN_RST   = 4'h1;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [15:0] LATCH_RST = 16'h0000;
  localparam logic [15:0] STAGE_RST = 16'h0000;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int STAGGER_STEP_NS = 5;
  // Whole cycles of stagger for the highest channel, rounded up
  localparam int STAGGER_MAX_CYC =
    ((CHANNELS - 1) * STAGGER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Stagger of one channel in clock cycles, rounded up
  function automatic int stagger_cyc(input int idx);
    return (idx * STAGGER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction
endpackage

// *** logic/led_shift_latch_driver.sv ***
// Serial shift register, level latch, enable gate and staggered sinks
`timescale 1ns/10ps
module led_shift_latch_driver
  import led_drv_pkg::*;
#(
  parameter int WIDTH = CHANNELS
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  // Serial control pins from the host
  input  wire logic             ser_data_in,
  input  wire logic             shift_clk_in,
  input  wire logic             load_strobe_in,
  input  wire logic             out_enable_n_in,
  // Cascade and channel outputs
  output logic                  cascade_out,
  output logic [WIDTH-1:0]      channel_sink_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] sync1_ff;
  logic [PIN_COUNT-1:0] sync2_ff;
  logic [PIN_COUNT-1:0] sync3_ff;
  logic [PIN_COUNT-1:0] flt_ff;
  logic [PIN_COUNT-1:0] nxt_flt;

  assign pin_raw[PIN_ENABLE_N]  = out_enable_n_in;
  assign pin_raw[PIN_STROBE]    = load_strobe_in;
  assign pin_raw[PIN_SHIFT_CLK] = shift_clk_in;
  assign pin_raw[PIN_SER_DATA]  = ser_data_in;

  // A pin level counts only once stages two and three agree
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      nxt_flt[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : flt_ff[i];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sync1_ff <= PIN_RST;
      sync2_ff <= PIN_RST;
      sync3_ff <= PIN_RST;
      flt_ff   <= PIN_RST;
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      flt_ff   <= nxt_flt;
    end
  end

  // Filtered pin levels
  logic en_n_flt;
  logic strobe_flt;
  logic data_flt;
  logic clk_flt;
  logic clk_rise;

  assign en_n_flt   = flt_ff[PIN_ENABLE_N];
  assign strobe_flt = flt_ff[PIN_STROBE];
  assign data_flt   = flt_ff[PIN_SER_DATA];
  assign clk_flt    = flt_ff[PIN_SHIFT_CLK];
  // Edge taken on the filtered level, so glitches never shift twice
  assign clk_rise   = nxt_flt[PIN_SHIFT_CLK] & ~clk_flt;

  // ----------------------------------------------------------------
  // Shift register and cascade
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] shift_ff;
  logic [WIDTH-1:0] nxt_shift;
  logic             cascade_ff;
  logic             nxt_cascade;
  logic             data_at_edge;

  // Data filtered in step with the clock, so edge and bit stay aligned
  assign data_at_edge = nxt_flt[PIN_SER_DATA];

  always_comb begin
    nxt_shift   = shift_ff;
    nxt_cascade = cascade_ff;
    if (clk_rise) begin
      nxt_shift   = {shift_ff[WIDTH-2:0], data_at_edge};
      nxt_cascade = shift_ff[WIDTH-2];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      shift_ff   <= SHIFT_RST;
      cascade_ff <= 1'b0;
    end else begin
      shift_ff   <= nxt_shift;
      cascade_ff <= nxt_cascade;
    end
  end

  // Cascade always equals the last shift stage
  assign cascade_out = cascade_ff;

  // ----------------------------------------------------------------
  // Level latch
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] latch_ff;
  logic [WIDTH-1:0] nxt_latch;

  // Level sensitive: follows every shift while strobe stays high
  always_comb begin
    nxt_latch = strobe_flt ? shift_ff : latch_ff;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      latch_ff <= LATCH_RST;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  // ----------------------------------------------------------------
  // Enable gate and staggered sink delay line
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] gated;
  logic [WIDTH-1:0] stage_ff  [0:STAGGER_MAX_CYC];
  logic [WIDTH-1:0] nxt_stage [0:STAGGER_MAX_CYC];

  // Bit one drives the sink on; enable high blanks every channel
  assign gated = en_n_flt ? '0 : latch_ff;

  // The gated pattern is delayed, not the enable, so each channel
  // keeps the whole pulse width and merely starts later
  always_comb begin
    nxt_stage[0] = gated;
    for (int k = 1; k <= STAGGER_MAX_CYC; k++) begin
      nxt_stage[k] = stage_ff[k-1];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      for (int k = 0; k <= STAGGER_MAX_CYC; k++) begin
        stage_ff[k] <= STAGE_RST;
      end
    end else begin
      for (int k = 0; k <= STAGGER_MAX_CYC; k++) begin
        stage_ff[k] <= nxt_stage[k];
      end
    end
  end

  // Each channel taps the stage matching its own stagger
  for (genvar i = 0; i < WIDTH; i++) begin : g_tap
    localparam int TAP = stagger_cyc(i);
    assign channel_sink_out[i] = stage_ff[TAP][i];
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence blank_hold_s;
    en_n_flt [*3];
  endsequence

  shift_advance_a: assert property (
    clk_rise |=> shift_ff == {$past(shift_ff[WIDTH-2:0]), $past(data_at_edge)})
    else $error("shift register did not advance on clock rise");

  shift_idle_a: assert property (
    !clk_rise |=> $stable(shift_ff))
    else $error("shift register moved without clock rise");

  cascade_stage_a: assert property (
    ##1 cascade_out == shift_ff[WIDTH-1])
    else $error("cascade output differs from last stage");

  latch_follow_a: assert property (
    strobe_flt |=> latch_ff == $past(shift_ff))
    else $error("latch did not follow shift register");

  latch_hold_a: assert property (
    !strobe_flt |=> $stable(latch_ff))
    else $error("latch changed while strobe low");

  enable_blank_a: assert property (
    blank_hold_s |=> channel_sink_out == '0)
    else $error("sinks on while enable held high");

  first_channel_a: assert property (
    !en_n_flt |=> channel_sink_out[0] == $past(latch_ff[0]))
    else $error("channel zero does not match latched bit");

  last_stagger_a: assert property (
    ##3 channel_sink_out[WIDTH-1] == $past(gated[WIDTH-1], 3))
    else $error("last channel stagger wrong");

  mid_stagger_a: assert property (
    ##2 channel_sink_out[8] == $past(gated[8], 2))
    else $error("middle channel stagger wrong");

  chan_zero_off_a: assert property (
    en_n_flt |=> !channel_sink_out[0])
    else $error("channel zero on while enable high");

endmodule

// *** verification/host_pin_model.sv ***
// Host pin model driving the serial control pins of the sink driver
`timescale 1ns/10ps
module host_pin_model (
  // Clock
  input  wire logic clk_in,
  // Pins towards the driver
  output logic      ser_data_out,
  output logic      shift_clk_out,
  output logic      strobe_out,
  output logic      enable_n_out
);
  // Idle levels: enable off, strobe low, data low
  initial begin
    ser_data_out  = 1'b0;
    shift_clk_out = 1'b0;
    strobe_out    = 1'b0;
    enable_n_out  = 1'b1;
  end
  // Enable and strobe levels, applied at the next edge
  task automatic drive(input logic en_n, input logic stb);
    @(posedge clk_in);
    enable_n_out <= en_n;
    strobe_out   <= stb;
  endtask
  // Top n bits of w, first bit first; three cycles per level for the filter
  task automatic shift_bits(input logic [15:0] w, input int n);
    @(posedge clk_in);
    for (int i = 15; i > 15 - n; i--) begin
      ser_data_out <= w[i];
      repeat (3) @(posedge clk_in);
      shift_clk_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      shift_clk_out <= 1'b0;
      // Data parks low so strobe high with enable low stays legal
      ser_data_out  <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask
endmodule

// *** verification/test_led_shift_latch_driver.sv ***
// Self-checking bench for the serial LED sink driver
`timescale 1ns/10ps
module test_led_shift_latch_driver;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        ser_data, shift_clk, strobe, enable_n, cascade;
  logic [15:0] sink;
  logic [31:0] cat      = 32'hA5C3_3C96;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  int          cycles     = 0;
  int          on_t[16];
  int          off_t[16];
  // Clock and hang guard
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  host_pin_model host (.clk_in(core_clk), .ser_data_out(ser_data),
    .shift_clk_out(shift_clk), .strobe_out(strobe), .enable_n_out(enable_n));
  led_shift_latch_driver dut (.core_clk_in(core_clk), .rst_n_in(rst_n),
    .ser_data_in(ser_data), .shift_clk_in(shift_clk), .load_strobe_in(strobe),
    .out_enable_n_in(enable_n), .cascade_out(cascade), .channel_sink_out(sink));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Let n edges pass, then look once outputs settle
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Pattern shifted and latched behind a closed enable
  task automatic t_gate();
    host.shift_bits(cat[31:16], 16);
    settle(0);
    check(cascade, cat[31]);
    host.drive(1'b1, 1'b1);
    settle(4);
    host.drive(1'b1, 1'b0);
    settle(12);
    check(sink, 16'h0000);
    host.drive(1'b0, 1'b0);
    settle(12);
    check(sink, cat[31:16]);
  endtask
  // Bit by bit shift while the latch holds, then load
  task automatic t_hold();
    for (int j = 1; j <= 16; j++) begin
      host.shift_bits(cat[15:0] << (j - 1), 1);
      settle(0);
      check(cascade, cat[31-j]);
    end
    check(sink, cat[31:16]);
    host.drive(1'b0, 1'b1);
    settle(12);
    check(sink, cat[15:0]);
    host.drive(1'b0, 1'b0);
  endtask
  // All channels on for a ten cycle enable pulse; record each edge
  task automatic t_stagger();
    host.drive(1'b1, 1'b0);
    host.shift_bits(16'hFFFF, 16);
    // Strobe must stand several cycles or the pin filter drops it
    host.drive(1'b1, 1'b1);
    settle(4);
    host.drive(1'b1, 1'b0);
    settle(4);
    on_t  = '{default: -1};
    off_t = '{default: -1};
    for (int c = 0; c < 40; c++) begin
      host.drive(!(c < 10), 1'b0);
      #1;
      for (int i = 0; i < 16; i++) begin
        if (sink[i] === 1'b1 && on_t[i] < 0) on_t[i] = c;
        if (sink[i] === 1'b0 && on_t[i] >= 0 && off_t[i] < 0) off_t[i] = c;
      end
    end
    for (int i = 0; i < 16; i++) begin
      check(16'(on_t[i] - on_t[0]), 16'((i * 5 + 39) / 40));
      check(16'(off_t[i] - on_t[i]), 16'd10);
    end
  endtask
  // Verdict
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    settle(9);
    check(sink, 16'h0000);
    check(cascade, 1'b0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    t_gate();
    t_hold();
    t_stagger();
    end_of_test();
  end
endmodule
